//--- include/lock_istream_pkg.sv
// Shared types and constants for the locked-update and I-stream coherency logic
package lock_istream_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int ADDR_W      = 64;
    localparam int DATA_W      = 64;
    localparam int BE_W        = 8;
    localparam int ASN_W       = 8;
    localparam int GRAN_SHIFT  = 4;
    localparam int GRAN_W      = ADDR_W - GRAN_SHIFT;
    localparam int LINE_SHIFT  = 5;
    localparam int VLINE_W     = ADDR_W - LINE_SHIFT;
    localparam int ITAG_N      = 4;
    localparam int ITAG_IDX_W  = 2;
    localparam int LW_SEL_BIT  = 2;
    localparam int LW_W        = 32;

    // ==========================================================
    // Byte-enable patterns and reset values
    // ==========================================================
    localparam logic [BE_W-1:0]       BE_QUAD    = 8'hFF;
    localparam logic [BE_W-1:0]       BE_LW_LO   = 8'h0F;
    localparam logic [BE_W-1:0]       BE_LW_HI   = 8'hF0;
    localparam logic [BE_W-1:0]       BE_NONE    = 8'h00;
    localparam logic [ADDR_W-1:0]     ADDR_ZERO  = 64'h0;
    localparam logic [DATA_W-1:0]     DATA_ZERO  = 64'h0;
    localparam logic [GRAN_W-1:0]     GRAN_ZERO  = 60'h0;
    localparam logic [VLINE_W-1:0]    VLINE_ZERO = 59'h0;
    localparam logic [ASN_W-1:0]      ASN_ZERO   = 8'h0;
    localparam logic [ITAG_IDX_W-1:0] IDX_ZERO   = 2'h0;
    localparam logic [ITAG_IDX_W-1:0] IDX_ONE    = 2'h1;

    // ==========================================================
    // Reservation states
    // ==========================================================
    typedef enum logic [0:0]
    {
        RESV_IDLE = 1'b0,
        RESV_HELD = 1'b1
    } resv_state_t;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed
    {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              quad;
        logic              via_taken_branch;
    } store_req_t;

    typedef struct packed
    {
        logic              valid;
        logic [ADDR_W-1:0] addr;
    } addr_req_t;

    typedef struct packed
    {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [BE_W-1:0]   be;
    } mem_wr_t;

    typedef struct packed
    {
        logic              valid;
        logic [ADDR_W-1:0] va;
        logic [ASN_W-1:0]  address_space_number;
    } ifetch_req_t;

    typedef struct packed
    {
        logic               valid;
        logic [VLINE_W-1:0] vline;
        logic [ASN_W-1:0]   address_space_number;
    } itag_entry_t;

endpackage

//--- rtl/istream_tag_store.sv
// Virtual instruction-line tag store, coherent only through barrier and unmap
`timescale 1ns/1ns
module istream_tag_store
    import lock_istream_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    input  wire logic        i_ce,
    // Fill and lookup
    input  wire ifetch_req_t i_fill,
    input  wire ifetch_req_t i_lookup,
    // Maintenance
    input  wire logic        i_istream_barrier,
    input  wire addr_req_t   i_unmap,
    // Result
    output logic             o_hit
);

    function automatic logic [VLINE_W-1:0] vline_of(input logic [ADDR_W-1:0] va);
        vline_of = va[ADDR_W-1:LINE_SHIFT];
    endfunction

    typedef struct packed
    {
        itag_entry_t [ITAG_N-1:0] ent;
        logic [ITAG_IDX_W-1:0]    fill_ptr;
        logic                     hit;
    } itag_state_t;

    itag_state_t            state_reg;
    itag_state_t            state_next;
    logic [ITAG_N-1:0]      look_match;
    logic [ITAG_N-1:0]      unmap_match;

    // ==========================================================
    // Per-entry compare
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < ITAG_N; g++)
        begin : g_cmp
            assign look_match[g]  = state_reg.ent[g].valid
                                 && state_reg.ent[g].vline == vline_of(i_lookup.va)
                                 && state_reg.ent[g].address_space_number == i_lookup.address_space_number; // [R11]
            assign unmap_match[g] = state_reg.ent[g].valid
                                 && state_reg.ent[g].vline == vline_of(i_unmap.addr);
        end
    endgenerate

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        state_next     = state_reg;
        state_next.hit = i_lookup.valid && (|look_match) && !i_istream_barrier;
        // Data stores never reach here: lines may go stale until a barrier
        if (i_fill.valid) // [R8]
        begin
            state_next.ent[state_reg.fill_ptr].valid = 1'b1;
            state_next.ent[state_reg.fill_ptr].vline = vline_of(i_fill.va);
            state_next.ent[state_reg.fill_ptr].address_space_number   = i_fill.address_space_number;
            state_next.fill_ptr                      = state_reg.fill_ptr + IDX_ONE;
        end
        // Unmapping drops the line so a remap to a copied frame refetches
        if (i_unmap.valid) // [R10]
        begin
            for (int k = 0; k < ITAG_N; k++)
            begin
                if (unmap_match[k])
                begin
                    state_next.ent[k].valid = 1'b0;
                end
            end
        end
        if (i_istream_barrier) // [R8]
        begin
            for (int k = 0; k < ITAG_N; k++)
            begin
                state_next.ent[k].valid = 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            for (int k = 0; k < ITAG_N; k++)
            begin
                state_reg.ent[k] <= '{valid: 1'b0, vline: VLINE_ZERO, address_space_number: ASN_ZERO};
            end
            state_reg.fill_ptr <= IDX_ZERO;
            state_reg.hit      <= 1'b0;
        end
        else if (i_ce)
        begin
            state_reg <= state_next;
        end
    end

    assign o_hit = state_reg.hit;

endmodule // istream_tag_store

//--- rtl/locked_update_unit.sv
// Reservation, conditional store, atomic plain store and I-stream tag tracking
//
// Summary of operation
// [R1] Undisturbed conditional store writes memory and returns result one.
// [R2] Exception, interrupt or foreign write makes conditional store skip memory, return zero.
// [R3] Interference is judged over the whole locked granule, not exact address.
// [R4] Any foreign write into the granule kills the reservation, regardless of value.
// [R5] Plain aligned longword or quadword store changes the datum in one write.
// [R6] Software keeps only register operate instructions inside the locked sequence.
// [R7] Conditional store reached through a taken branch is refused, returns zero.
// [R8] Instruction lines ignore data stores; stale lines live until the barrier.
// [R9] Software issues the I-stream barrier before running freshly written code.
// [R10] Unmap, copy, remap drops matching lines so fetch stays correct.
// [R11] Instruction line hit needs matching virtual line and address space number.
// [R12] Every longword or quadword write leaves in one beat, never partially.
// [R13] Any completed conditional store clears the reservation.
`timescale 1ns/1ns
module locked_update_unit
    import lock_istream_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              i_mclk,
    input  wire logic              i_reset,
    input  wire logic              i_ce,
    // Own core requests
    input  wire addr_req_t         i_load_locked_any_width,
    input  wire store_req_t        i_store_conditional_any_width,
    input  wire store_req_t        i_store_longword_plain,
    input  wire logic              i_exception_or_interrupt,
    // Writes by other processors and I/O agents
    input  wire addr_req_t         i_foreign_write,
    // Instruction stream
    input  wire ifetch_req_t       i_ifetch_fill,
    input  wire ifetch_req_t       i_ifetch_lookup,
    input  wire logic              i_istream_barrier,
    input  wire addr_req_t         i_unmap,
    // Memory write port
    output mem_wr_t                o_mem_wr,
    // Conditional store result
    output logic                   o_sc_done,
    output logic                   o_sc_success,
    // Status
    output logic                   o_resv_valid,
    output logic                   o_ifetch_hit
);

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [GRAN_W-1:0] granule_of(input logic [ADDR_W-1:0] a);
        granule_of = a[ADDR_W-1:GRAN_SHIFT];
    endfunction

    function automatic mem_wr_t build_write(input store_req_t r);
        build_write.valid = 1'b1;
        build_write.addr  = r.addr;
        if (r.quad)
        begin
            build_write.data = r.data;
            build_write.be   = BE_QUAD;
        end
        else
        begin
            // Longword replicated on both halves; lanes pick the live one
            build_write.data = {r.data[LW_W-1:0], r.data[LW_W-1:0]};
            build_write.be   = r.addr[LW_SEL_BIT] ? BE_LW_HI : BE_LW_LO;
        end
    endfunction

    typedef struct packed
    {
        resv_state_t       resv;
        logic [GRAN_W-1:0] granule;
        mem_wr_t           wr;
        logic              sc_done;
        logic              sc_success;
    } lock_state_t;

    lock_state_t state_reg;
    lock_state_t state_next;
    logic        interfere;
    logic        sc_ok;

    // ==========================================================
    // Interference and success decision
    // ==========================================================
    // No data compare: a same-value write still counts as interference
    assign interfere = i_exception_or_interrupt
                    || (i_foreign_write.valid
                        && granule_of(i_foreign_write.addr) == state_reg.granule); // [R3] [R4]

    assign sc_ok = state_reg.resv == RESV_HELD
                && !interfere                                                      // [R2]
                && granule_of(i_store_conditional_any_width.addr) == state_reg.granule
                && !i_store_conditional_any_width.via_taken_branch;                // [R7]

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        state_next            = state_reg;
        state_next.wr         = '{valid: 1'b0, addr: ADDR_ZERO, data: DATA_ZERO, be: BE_NONE};
        state_next.sc_done    = 1'b0;
        state_next.sc_success = 1'b0;

        unique case (state_reg.resv)
            RESV_IDLE:
            begin
                state_next.resv = RESV_IDLE;
            end
            RESV_HELD:
            begin
                if (interfere) // [R2] [R4]
                begin
                    state_next.resv = RESV_IDLE;
                end
            end
        endcase

        if (i_store_conditional_any_width.valid)
        begin
            state_next.sc_done    = 1'b1;
            state_next.sc_success = sc_ok;                               // [R1] [R2]
            state_next.resv       = RESV_IDLE;                           // [R13]
            if (sc_ok)
            begin
                state_next.wr = build_write(i_store_conditional_any_width); // [R1] [R12]
            end
        end
        else if (i_store_longword_plain.valid)
        begin
            // Whole datum in a single beat so no partial value is visible
            state_next.wr = build_write(i_store_longword_plain);         // [R5] [R12]
        end

        // A new locked load starts a fresh reservation after any completion
        if (i_load_locked_any_width.valid)
        begin
            state_next.resv    = RESV_HELD;
            state_next.granule = granule_of(i_load_locked_any_width.addr); // [R3]
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            state_reg.resv       <= RESV_IDLE;
            state_reg.granule    <= GRAN_ZERO;
            state_reg.wr         <= '{valid: 1'b0, addr: ADDR_ZERO, data: DATA_ZERO, be: BE_NONE};
            state_reg.sc_done    <= 1'b0;
            state_reg.sc_success <= 1'b0;
        end
        else if (i_ce)
        begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Instruction line tags
    // ==========================================================
    istream_tag_store u_itags
    (
        .i_mclk            (i_mclk),
        .i_reset           (i_reset),
        .i_ce              (i_ce),
        .i_fill            (i_ifetch_fill),
        .i_lookup          (i_ifetch_lookup),
        .i_istream_barrier (i_istream_barrier),
        .i_unmap           (i_unmap),
        .o_hit             (o_ifetch_hit)
    );

    // ==========================================================
    // Outputs
    // ==========================================================
    assign o_mem_wr     = state_reg.wr;
    assign o_sc_done    = state_reg.sc_done;
    assign o_sc_success = state_reg.sc_success;
    assign o_resv_valid = state_reg.resv == RESV_HELD;

endmodule // locked_update_unit

//--- sim/foreign_agent.sv
// Model of another agent writing into the shared memory
`timescale 1ns/1ns
module foreign_agent
    import lock_istream_pkg::*;
(
    // Clock
    input  wire logic i_mclk,
    // Write seen by the unit
    output addr_req_t o_write
);
    initial o_write = '0;

    // Lag lets the agent answer promptly or late
    task automatic write(input logic [ADDR_W-1:0] a, input int lag);
        @(negedge i_mclk);
        repeat (lag) @(negedge i_mclk);
        o_write = '{1'b1, a};
        @(negedge i_mclk);
        // Idle address scrambled so nothing leans on a stale value
        o_write = '{1'b0, ~a};
    endtask
endmodule // foreign_agent

//--- sim/locked_update_unit_props.sv
// Concurrent checks on the locked update unit ports
`timescale 1ns/1ns
module locked_update_props
    import lock_istream_pkg::*;
(
    // Clock and inputs
    input wire logic        i_mclk,
    input wire logic        i_reset,
    input wire logic        i_ce,
    input wire addr_req_t   i_load_locked_any_width,
    input wire store_req_t  i_store_conditional_any_width,
    input wire store_req_t  i_store_longword_plain,
    input wire logic        i_exception_or_interrupt,
    input wire addr_req_t   i_foreign_write,
    input wire ifetch_req_t i_ifetch_lookup,
    input wire logic        i_istream_barrier,
    // Outputs
    input wire mem_wr_t     o_mem_wr,
    input wire logic        o_sc_done,
    input wire logic        o_sc_success,
    input wire logic        o_resv_valid,
    input wire logic        o_ifetch_hit
);
    wire ll = i_ce && i_load_locked_any_width.valid;
    wire sc = i_ce && i_store_conditional_any_width.valid;
    wire tk = sc && i_store_conditional_any_width.via_taken_branch;
    wire st = i_ce && i_store_longword_plain.valid && !sc;
    wire ex = i_ce && i_exception_or_interrupt;
    wire fw = i_ce && i_foreign_write.valid && (i_foreign_write.addr[ADDR_W-1:GRAN_SHIFT]
        == i_store_conditional_any_width.addr[ADDR_W-1:GRAN_SHIFT]);

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);

    chk_sc_answers: assert property (sc |=> o_sc_done)
        else $error("conditional store got no answer");
    chk_win_writes: assert property (o_sc_success |-> o_sc_done && o_mem_wr.valid)
        else $error("success without memory write");
    chk_no_resv: assert property (sc && !o_resv_valid |=> !o_sc_success)
        else $error("success without reservation");
    chk_exc_fails: assert property (sc && ex |=> !o_sc_success)
        else $error("success across exception");
    chk_gran_fails: assert property (sc && fw |=> !o_sc_success)
        else $error("success across foreign write");
    chk_branch_fails: assert property (tk |=> !o_sc_success)
        else $error("success after taken branch");
    chk_ll_sets: assert property (ll |=> o_resv_valid)
        else $error("locked load set no reservation");
    // Exception alone also kills it, so no stale reservation survives a trap
    chk_resv_drops: assert property ((sc || ex) && !ll |=> !o_resv_valid)
        else $error("reservation survived");
    chk_plain_beat: assert property (st |=> o_mem_wr.valid && o_mem_wr.be ==
        ($past(i_store_longword_plain.quad) ? BE_QUAD :
        $past(i_store_longword_plain.addr[LW_SEL_BIT]) ? BE_LW_HI : BE_LW_LO))
        else $error("plain store not one whole beat");
    chk_bar_miss: assert property (i_ce && i_ifetch_lookup.valid && i_istream_barrier
        |=> !o_ifetch_hit)
        else $error("hit beside barrier");

    cov_sc_win: cover property (o_sc_success);
    cov_sc_lose: cover property (o_sc_done && !o_sc_success);
    cov_hit: cover property (o_ifetch_hit);
endmodule // locked_update_props

bind locked_update_unit locked_update_props u_props (
    .i_mclk, .i_reset, .i_ce, .i_load_locked_any_width, .i_store_conditional_any_width,
    .i_store_longword_plain, .i_exception_or_interrupt, .i_foreign_write, .i_ifetch_lookup,
    .i_istream_barrier, .o_mem_wr, .o_sc_done, .o_sc_success, .o_resv_valid, .o_ifetch_hit
);

//--- sim/tb.sv
// Self-checking bench for the locked update unit
`timescale 1ns/1ns
module tb
    import lock_istream_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        ce;
    logic        exc;
    logic        bar;
    addr_req_t   ll_r;
    addr_req_t   um_r;
    addr_req_t   fw;
    store_req_t  sc_r;
    store_req_t  st_r;
    ifetch_req_t fl_r;
    ifetch_req_t lk_r;
    mem_wr_t     wr;
    logic        done;
    logic        ok;
    logic        resv;
    logic        hit;
    int          n_errors;
    int          checked;
    int          seed;
    logic [63:0] a;
    logic [63:0] d;

    locked_update_unit dut (
        .i_mclk(clk), .i_reset(rst), .i_ce(ce), .i_load_locked_any_width(ll_r),
        .i_store_conditional_any_width(sc_r), .i_store_longword_plain(st_r),
        .i_exception_or_interrupt(exc), .i_foreign_write(fw), .i_ifetch_fill(fl_r),
        .i_ifetch_lookup(lk_r), .i_istream_barrier(bar), .i_unmap(um_r), .o_mem_wr(wr),
        .o_sc_done(done), .o_sc_success(ok), .o_resv_valid(resv), .o_ifetch_hit(hit)
    );
    foreign_agent u_agent (.i_mclk(clk), .o_write(fw));

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic chk1(input logic got, input logic exp, input string m);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    task automatic chk_wr(input mem_wr_t exp);
        checked++;
        if (wr.valid !== exp.valid || (exp.valid && wr !== exp))
        begin
            n_errors++;
            $display("[FAIL] %0t memory write", $time);
        end
    endtask

    function automatic mem_wr_t exp_wr(input logic q);
        exp_wr = '{1'b1, a, q ? d : {2{d[LW_W-1:0]}},
                   q ? BE_QUAD : (a[LW_SEL_BIT] ? BE_LW_HI : BE_LW_LO)};
    endfunction

    task automatic sc_op(input logic q, input logic tk, input logic exp);
        @(negedge clk);
        sc_r = '{1'b1, a, d, q, tk};
        @(negedge clk);
        sc_r = '0;
        chk1(done, 1'b1, "sc answer");
        chk1(ok, exp, "sc result");
        chk1(resv, 1'b0, "reservation kept");
        chk_wr(exp ? exp_wr(q) : '0);
    endtask

    task automatic hazard(input int m, input int lag);
        if (m == 1)
            u_agent.write({a[63:4], a[3:0] ^ 4'h8}, lag);
        if (m == 2)
        begin
            @(negedge clk);
            exc = 1'b1;
            @(negedge clk);
            exc = 1'b0;
        end
    endtask

    // Kind: 0 fill, 1 lookup, 2 barrier with lookup, 3 unmap
    task automatic if_op(input int kind, input logic [7:0] address_space_number, input logic exp);
        @(negedge clk);
        fl_r = '{kind == 0, a, address_space_number};
        lk_r = '{kind == 1 || kind == 2, a, address_space_number};
        bar = (kind == 2);
        um_r = '{kind == 3, a};
        @(negedge clk);
        {fl_r, lk_r, bar, um_r} = '0;
        if (kind == 1 || kind == 2)
            chk1(hit, exp, "lookup");
    endtask

    task automatic wrap_up();
        $display("Counts: %0d compares, %0d mismatches", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Roughly eighteen times the length of the sequence below
    initial
    begin
        repeat (3000) @(posedge clk);
        n_errors++;
        $display("[FAIL] %0t watchdog", $time);
        wrap_up();
    end

    // ==========================================================
    // Sequence
    // ==========================================================
    initial
    begin
        {ll_r, um_r, sc_r, st_r, fl_r, lk_r, exc, bar} = '0;
        {n_errors, checked} = '0;
        seed = 32'hF70E9F69;
        ce = 1'b1;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        // Mode k%4: clean, foreign write, exception, taken branch
        for (int k = 0; k < 24; k++)
        begin
            a = {$random(seed), $random(seed)};
            d = {$random(seed), $random(seed)};
            a[1:0] = 2'h0;
            a[2] = a[2] & !k[2];
            @(negedge clk);
            // Nothing but hazards between locked load and conditional store
            ll_r = '{1'b1, a};
            @(negedge clk);
            ll_r = '0;
            chk1(resv, 1'b1, "reservation");
            if (!k[3])
                hazard(k % 4, 1);
            fork
                if (k[3]) hazard(k % 4, 0);
                sc_op(k[2], k % 4 == 3, k % 4 == 0);
            join
        end
        $display("Test locked sequences done");
        a[2:0] = 3'h0;
        sc_op(1'b1, 1'b0, 1'b0);
        @(negedge clk);
        ll_r = '{1'b1, a};
        @(negedge clk);
        ll_r = '0;
        u_agent.write(a + 64'h10, 0);
        sc_op(1'b1, 1'b0, 1'b1);
        // Enable low must freeze the reservation against a trap
        @(negedge clk);
        ll_r = '{1'b1, a};
        @(negedge clk);
        ll_r = '0;
        ce = 1'b0;
        exc = 1'b1;
        @(negedge clk);
        ce = 1'b1;
        exc = 1'b0;
        chk1(resv, 1'b1, "enable low did not freeze");
        sc_op(1'b1, 1'b0, 1'b1);
        for (int j = 0; j < 3; j++)
        begin
            a[2] = j[0];
            d = {$random(seed), $random(seed)};
            @(negedge clk);
            st_r = '{1'b1, a, d, j[1], 1'b0};
            @(negedge clk);
            st_r = '0;
            chk_wr(exp_wr(j[1]));
        end
        $display("Test plain stores done");
        if_op(0, d[7:0], 1'b0);
        if_op(1, d[7:0], 1'b1);
        if_op(1, ~d[7:0], 1'b0);
        // Data store onto the cached line must leave the tag alone
        @(negedge clk);
        st_r = '{1'b1, a, d, 1'b1, 1'b0};
        @(negedge clk);
        st_r = '0;
        chk_wr(exp_wr(1'b1));
        if_op(1, d[7:0], 1'b1);
        if_op(3, d[7:0], 1'b0);
        if_op(1, d[7:0], 1'b0);
        if_op(0, d[7:0], 1'b0);
        if_op(2, d[7:0], 1'b0);
        if_op(1, d[7:0], 1'b0);
        $display("Test instruction lines done");
        wrap_up();
    end
endmodule // tb
